// File: src/fp_cond_move_multiply_unit.v
// float execution slice: conditional move, multiply family, prefetch
`timescale 1ns/1ps
`include "fp_unit_map.vh"
module fp_cond_move_multiply_unit (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // issue side
  input wire issue_valid,
  input wire [31:0] instr,
  input wire coprocessor_enabled,
  input wire [1:0] rounding_mode,
  // integer operand values
  input wire [63:0] tested_integer_value,
  input wire [63:0] base_integer_value,
  input wire [63:0] index_integer_value,
  // float operand values
  input wire [63:0] source_float_value,
  input wire [63:0] second_float_value,
  input wire [63:0] addend_float_value,
  // memory type of the prefetch address
  input wire page_uncached,
  // float register write
  output wire result_valid,
  output wire result_write,
  output wire result_write_upper,
  output wire [4:0] result_register,
  output wire [63:0] result_data,
  // exception conditions
  output wire exc_cop_unusable,
  output wire exc_reserved_instr,
  output wire exc_inexact,
  output wire exc_invalid,
  output wire exc_underflow,
  output wire exc_overflow,
  // prefetch request
  output wire prefetch_valid,
  output wire [63:0] prefetch_address,
  output wire [4:0] prefetch_hint
);

  // ----------
  // instruction fields
  // ----------
  wire [5:0] major = instr[`POS_MAJOR_HI:`POS_MAJOR_LO];
  wire [4:0] fmt5 = instr[`POS_FMT_HI:`POS_FMT_LO];
  wire [4:0] src_field = instr[`POS_SRC_HI:`POS_SRC_LO];
  wire [4:0] dest_field = instr[`POS_DEST_HI:`POS_DEST_LO];
  wire [5:0] func = instr[5:0];
  wire [2:0] fmt3 = instr[2:0];
  wire [2:0] func3 = instr[5:3];

  // ----------
  // decode
  // ----------
  wire is_std = major == `OPC_FLOAT_OP;
  wire is_ext = major == `OPC_EXT_FLOAT_OP;
  wire std_fmt_ok = (fmt5 == `FMT_SINGLE) | (fmt5 == `FMT_DOUBLE);
  wire ext_fmt_ok = (fmt3 == `FMT3_SINGLE) | (fmt3 == `FMT3_DOUBLE);
  wire dbl = is_ext ? (fmt3 == `FMT3_DOUBLE) : (fmt5 == `FMT_DOUBLE);
  wire op_word_move = is_std & (fmt5 == `FMT_MOVE_TO);
  wire op_multiply = is_std & std_fmt_ok & (func == `FN_FLOAT_MULTIPLY);
  wire op_negate = is_std & std_fmt_ok & (func == `FN_NEGATE);
  wire op_move_zero = is_std & std_fmt_ok & (func == `FN_MOVE_ON_ZERO);
  wire op_prefetch = is_ext & (func == `FN_INDEXED_PREFETCH);
  wire fn_fsub = func3 == `FN3_FUSED_SUB;
  wire fn_nadd = func3 == `FN3_NEG_ADD;
  wire fn_nsub = func3 == `FN3_NEG_SUB;
  wire op_fused = is_ext & ext_fmt_ok & (fn_fsub | fn_nadd | fn_nsub);
  wire known = op_word_move | op_multiply | op_negate | op_move_zero |
               op_prefetch | op_fused;
  wire go = issue_valid & coprocessor_enabled;

  // fused controls: subtract the addend, negate after rounding
  wire sub_addend = fn_fsub | fn_nsub;
  wire negate_result = fn_nadd | fn_nsub;

  // ----------
  // arithmetic cores, one per width; both use the fused model
  // ----------
  wire [31:0] s_result;
  wire s_inexact;
  wire s_invalid;
  wire s_underflow;
  wire s_overflow;
  wire [63:0] d_result;
  wire d_inexact;
  wire d_invalid;
  wire d_underflow;
  wire d_overflow;

  // single width core; the product alone for plain multiply
  fp_fused_core #(
    .EXP_W(8),
    .FRAC_W(23)
  ) u_single (
    .mult_a(source_float_value[31:0]),
    .mult_b(second_float_value[31:0]),
    .addend(addend_float_value[31:0]),
    .rounding_mode(rounding_mode),
    .sub_addend(sub_addend),
    .negate(negate_result),
    .product_only(op_multiply),
    .result(s_result),
    .inexact(s_inexact),
    .invalid(s_invalid),
    .underflow(s_underflow),
    .overflow(s_overflow)
  );

  // double width core
  fp_fused_core #(
    .EXP_W(11),
    .FRAC_W(52)
  ) u_double (
    .mult_a(source_float_value),
    .mult_b(second_float_value),
    .addend(addend_float_value),
    .rounding_mode(rounding_mode),
    .sub_addend(sub_addend),
    .negate(negate_result),
    .product_only(op_multiply),
    .result(d_result),
    .inexact(d_inexact),
    .invalid(d_invalid),
    .underflow(d_underflow),
    .overflow(d_overflow)
  );

  // ----------
  // negate helpers
  // ----------
  wire s_nan = (&source_float_value[30:23]) & (|source_float_value[22:0]);
  wire d_nan = (&source_float_value[62:52]) & (|source_float_value[51:0]);
  wire [63:0] neg_value = dbl ?
      {~source_float_value[63], source_float_value[62:0]} :
      {32'h00000000, ~source_float_value[31], source_float_value[30:0]};

  // prefetch hint: undefined values fall back to a plain load hint
  wire hint_defined = (src_field <= `HINT_LAST_DEFINED) &
                      (src_field[2:1] != 2'b01);
  wire [4:0] hint_used = hint_defined ? src_field : `HINT_LOAD;

  // ----------
  // next values
  // ----------
  reg result_valid_d;
  reg result_write_d;
  reg result_write_upper_d;
  reg [4:0] result_register_d;
  reg [63:0] result_data_d;
  reg exc_cop_unusable_d;
  reg exc_reserved_instr_d;
  reg exc_inexact_d;
  reg exc_invalid_d;
  reg exc_underflow_d;
  reg exc_overflow_d;
  reg prefetch_valid_d;
  reg [63:0] prefetch_address_d;
  reg [4:0] prefetch_hint_d;

  // one decision per issued instruction; nothing is written early
  always @* begin
    result_valid_d = issue_valid;
    result_write_d = 1'b0;
    result_write_upper_d = 1'b0;
    result_register_d = dest_field;
    result_data_d = `DATA_RESET;
    exc_cop_unusable_d = issue_valid & ~coprocessor_enabled;
    exc_reserved_instr_d = go & ~known;
    exc_inexact_d = 1'b0;
    exc_invalid_d = 1'b0;
    exc_underflow_d = 1'b0;
    exc_overflow_d = 1'b0;
    prefetch_valid_d = 1'b0;
    prefetch_address_d = base_integer_value + index_integer_value;
    prefetch_hint_d = hint_used;
    if (go) begin
      if (op_move_zero) begin
        // copy only on zero; flags stay clear either way
        result_write_d = tested_integer_value == 64'h0;
        result_write_upper_d = dbl & result_write_d;
        result_data_d = dbl ? source_float_value :
                        {32'h00000000, source_float_value[31:0]};
      end else if (op_word_move) begin
        // destination is named by the source field here
        result_write_d = 1'b1;
        result_register_d = src_field;
        result_data_d = {32'h00000000, tested_integer_value[31:0]};
      end else if (op_negate) begin
        result_write_d = 1'b1;
        result_write_upper_d = dbl;
        result_data_d = neg_value;
        exc_invalid_d = dbl ? d_nan : s_nan;
      end else if (op_multiply | op_fused) begin
        result_write_d = 1'b1;
        result_write_upper_d = dbl;
        result_data_d = dbl ? d_result :
                        {32'h00000000, s_result};
        exc_inexact_d = dbl ? d_inexact : s_inexact;
        exc_invalid_d = dbl ? d_invalid : s_invalid;
        exc_underflow_d = dbl ? d_underflow : s_underflow;
        exc_overflow_d = dbl ? d_overflow : s_overflow;
      end else if (op_prefetch) begin
        // advisory only: no register write, no flag, no exception
        prefetch_valid_d = ~page_uncached;
      end
    end
  end

  // ----------
  // registered outputs; the write lands at completion only
  // ----------
  reg result_valid_q;
  reg result_write_q;
  reg result_write_upper_q;
  reg [4:0] result_register_q;
  reg [63:0] result_data_q;
  reg exc_cop_unusable_q;
  reg exc_reserved_instr_q;
  reg exc_inexact_q;
  reg exc_invalid_q;
  reg exc_underflow_q;
  reg exc_overflow_q;
  reg prefetch_valid_q;
  reg [63:0] prefetch_address_q;
  reg [4:0] prefetch_hint_q;

  // single stage: all strobes live for exactly one cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      result_valid_q <= 1'b0;
      result_write_q <= 1'b0;
      result_write_upper_q <= 1'b0;
      result_register_q <= `REG_RESET;
      result_data_q <= `DATA_RESET;
      exc_cop_unusable_q <= 1'b0;
      exc_reserved_instr_q <= 1'b0;
      exc_inexact_q <= 1'b0;
      exc_invalid_q <= 1'b0;
      exc_underflow_q <= 1'b0;
      exc_overflow_q <= 1'b0;
      prefetch_valid_q <= 1'b0;
      prefetch_address_q <= `ADDR_RESET;
      prefetch_hint_q <= `REG_RESET;
    end else begin
      result_valid_q <= result_valid_d;
      result_write_q <= result_write_d;
      result_write_upper_q <= result_write_upper_d;
      result_register_q <= result_register_d;
      result_data_q <= result_data_d;
      exc_cop_unusable_q <= exc_cop_unusable_d;
      exc_reserved_instr_q <= exc_reserved_instr_d;
      exc_inexact_q <= exc_inexact_d;
      exc_invalid_q <= exc_invalid_d;
      exc_underflow_q <= exc_underflow_d;
      exc_overflow_q <= exc_overflow_d;
      prefetch_valid_q <= prefetch_valid_d;
      prefetch_address_q <= prefetch_address_d;
      prefetch_hint_q <= prefetch_hint_d;
    end
  end

  // ----------
  // port drive
  // ----------
  assign result_valid = result_valid_q;
  assign result_write = result_write_q;
  assign result_write_upper = result_write_upper_q;
  assign result_register = result_register_q;
  assign result_data = result_data_q;
  assign exc_cop_unusable = exc_cop_unusable_q;
  assign exc_reserved_instr = exc_reserved_instr_q;
  assign exc_inexact = exc_inexact_q;
  assign exc_invalid = exc_invalid_q;
  assign exc_underflow = exc_underflow_q;
  assign exc_overflow = exc_overflow_q;
  assign prefetch_valid = prefetch_valid_q;
  assign prefetch_address = prefetch_address_q;
  assign prefetch_hint = prefetch_hint_q;

endmodule // fp_cond_move_multiply_unit

// File: inc/fp_unit_map.vh
// opcode, field and reset constants for the float execution slice
`ifndef FP_UNIT_MAP_VH
`define FP_UNIT_MAP_VH

// ----------
// major opcodes
// ----------
`define OPC_FLOAT_OP 6'h11
`define OPC_EXT_FLOAT_OP 6'h13

// ----------
// format codes
// ----------
`define FMT_SINGLE 5'h10
`define FMT_DOUBLE 5'h11
`define FMT_MOVE_TO 5'h04
`define FMT3_SINGLE 3'h0
`define FMT3_DOUBLE 3'h1

// ----------
// function codes
// ----------
`define FN_FLOAT_MULTIPLY 6'h02
`define FN_NEGATE 6'h07
`define FN_MOVE_ON_ZERO 6'h12
`define FN_INDEXED_PREFETCH 6'h0f
`define FN3_FUSED_SUB 3'h5
`define FN3_NEG_ADD 3'h6
`define FN3_NEG_SUB 3'h7

// ----------
// field positions inside the instruction word
// ----------
`define POS_MAJOR_HI 31
`define POS_MAJOR_LO 26
`define POS_FMT_HI 25
`define POS_FMT_LO 21
`define POS_SRC_HI 15
`define POS_SRC_LO 11
`define POS_DEST_HI 10
`define POS_DEST_LO 6

// ----------
// rounding modes and prefetch hints
// ----------
`define RM_NEAREST 2'h0
`define RM_ZERO 2'h1
`define RM_UP 2'h2
`define RM_DOWN 2'h3
`define HINT_LOAD 5'h00
`define HINT_LAST_DEFINED 5'h07

// ----------
// reset values and timing
// ----------
`define DATA_RESET 64'h0000000000000000
`define ADDR_RESET 64'h0000000000000000
`define REG_RESET 5'h00
`define RESULT_LATENCY 1

`endif

// File: src/fp_fused_core.v
// fused multiply-add datapath for one float width, combinational
`timescale 1ns/1ps
`include "fp_unit_map.vh"
module fp_fused_core #(
  parameter EXP_W = 8,
  parameter FRAC_W = 23
) (
  // operands
  input wire [EXP_W+FRAC_W:0] mult_a,
  input wire [EXP_W+FRAC_W:0] mult_b,
  input wire [EXP_W+FRAC_W:0] addend,
  // controls
  input wire [1:0] rounding_mode,
  input wire sub_addend,
  input wire negate,
  input wire product_only,
  // result and flags
  output reg [EXP_W+FRAC_W:0] result,
  output reg inexact,
  output reg invalid,
  output reg underflow,
  output reg overflow
);
  localparam W = EXP_W + FRAC_W + 1;
  localparam K = 2 * FRAC_W + 6;
  localparam XW = EXP_W + 3;
  localparam [XW-1:0] BIAS = {4'h0, {(EXP_W-1){1'b1}}};
  localparam [XW-1:0] ONE_X = {{(XW-1){1'b0}}, 1'b1};
  localparam [EXP_W-1:0] EXP_ONES = {EXP_W{1'b1}};
  localparam [W-1:0] QNAN = {1'b0, EXP_ONES, 1'b1, {(FRAC_W-1){1'b0}}};
  localparam [W-2:0] INF_MAG = {EXP_ONES, {FRAC_W{1'b0}}};
  localparam [W-2:0] MAX_MAG = {EXP_ONES - 1'b1, {FRAC_W{1'b1}}};

  // ----------
  // operand unpack; subnormals are flushed to zero
  // ----------
  wire [EXP_W-1:0] ea = mult_a[W-2:FRAC_W];
  wire [EXP_W-1:0] eb = mult_b[W-2:FRAC_W];
  wire [EXP_W-1:0] ec = addend[W-2:FRAC_W];
  wire [FRAC_W-1:0] fa = mult_a[FRAC_W-1:0];
  wire [FRAC_W-1:0] fb = mult_b[FRAC_W-1:0];
  wire [FRAC_W-1:0] fc = addend[FRAC_W-1:0];
  wire nan_a = (ea == EXP_ONES) & (|fa);
  wire nan_b = (eb == EXP_ONES) & (|fb);
  wire nan_c = (ec == EXP_ONES) & (|fc) & ~product_only;
  wire nan_any = nan_a | nan_b | nan_c;
  wire snan_any = (nan_a & ~fa[FRAC_W-1]) | (nan_b & ~fb[FRAC_W-1]) |
                  (nan_c & ~fc[FRAC_W-1]);
  wire inf_p = ((ea == EXP_ONES) & ~|fa) | ((eb == EXP_ONES) & ~|fb);
  wire inf_c = (ec == EXP_ONES) & ~|fc & ~product_only;
  wire zp = (ea == {EXP_W{1'b0}}) | (eb == {EXP_W{1'b0}});
  wire zc = (ec == {EXP_W{1'b0}}) | product_only;
  wire sp = mult_a[W-1] ^ mult_b[W-1];
  wire sc = product_only ? sp : addend[W-1] ^ sub_addend;

  // exact product and both magnitudes on one scale
  wire [2*FRAC_W+1:0] prod = {1'b1, fa} * {1'b1, fb};
  wire [XW-1:0] ep = {3'h0, ea} + {3'h0, eb} - BIAS + ONE_X;
  wire [XW-1:0] ec1 = {3'h0, ec} + ONE_X;
  wire [K-1:0] pm = {1'b0, prod, 3'h0};
  wire [K-1:0] cm = {2'h0, 1'b1, fc, {(FRAC_W+3){1'b0}}};

  reg [K-1:0] big;
  reg [K-1:0] sml;
  reg [K-1:0] sum;
  reg [K-1:0] norm;
  reg [XW-1:0] ebig;
  reg [XW-1:0] diff;
  reg sbig;
  reg ssml;
  reg rsign;
  reg stk_s;
  reg rnd;
  reg stk;
  reg inc;
  reg ovf_inf;
  reg is_nan;
  reg [FRAC_W-1:0] frac;
  reg [W-2:0] pk;
  integer i;
  integer p;
  integer te;

  // ----------
  // align, add, normalise, round once: the fused model throughout
  // ----------
  always @* begin
    big = pm;
    sml = cm;
    ebig = ep;
    diff = ep - ec1;
    sbig = sp;
    ssml = sc;
    stk_s = 1'b0;
    p = 0;
    inc = 1'b0;
    is_nan = 1'b0;
    result = {W{1'b0}};
    inexact = 1'b0;
    invalid = 1'b0;
    underflow = 1'b0;
    overflow = 1'b0;
    if (zp) begin
      big = cm;
      sml = {K{1'b0}};
      ebig = ec1;
      sbig = sc;
    end else if (zc) begin
      sml = {K{1'b0}};
    end else if ($signed(ep) < $signed(ec1)) begin
      big = cm;
      sml = pm;
      ebig = ec1;
      diff = ec1 - ep;
      sbig = sc;
      ssml = sp;
    end
    // bits shifted out fold into a sticky bit so rounding still sees them
    for (i = 0; i < K; i = i + 1)
      if (i < diff) stk_s = stk_s | sml[i];
    sml = (sml >> diff) | {{(K-1){1'b0}}, stk_s};
    if (sbig == ssml) begin
      sum = big + sml;
      rsign = sbig;
    end else if (big >= sml) begin
      sum = big - sml;
      rsign = sbig;
    end else begin
      sum = sml - big;
      rsign = ssml;
    end
    for (i = 0; i < K; i = i + 1)
      if (sum[i]) p = i;
    norm = sum << (K - 1 - p);
    te = $signed(ebig) + p - (K - 2);
    frac = norm[K-2:K-1-FRAC_W];
    rnd = norm[K-2-FRAC_W];
    stk = |norm[K-3-FRAC_W:0];
    case (rounding_mode)
      `RM_NEAREST: inc = rnd & (stk | frac[0]);
      `RM_UP: inc = ~rsign & (rnd | stk);
      `RM_DOWN: inc = rsign & (rnd | stk);
      default: inc = 1'b0;
    endcase
    pk = {te[EXP_W-1:0], frac} + {{(W-2){1'b0}}, inc};
    ovf_inf = (rounding_mode == `RM_NEAREST) |
              ((rounding_mode == `RM_UP) & ~rsign) |
              ((rounding_mode == `RM_DOWN) & rsign);
    if (nan_any) begin
      result = QNAN;
      invalid = snan_any;
      is_nan = 1'b1;
    end else if ((inf_p & zp) | (inf_p & inf_c & (sp != sc))) begin
      result = QNAN;
      invalid = 1'b1;
      is_nan = 1'b1;
    end else if (inf_p) begin
      result = {sp, INF_MAG};
    end else if (inf_c) begin
      result = {sc, INF_MAG};
    end else if (zp & zc) begin
      result = {(sp == sc) ? sp : (rounding_mode == `RM_DOWN),
                {(W-1){1'b0}}};
    end else if (sum == {K{1'b0}}) begin
      result = {rounding_mode == `RM_DOWN, {(W-1){1'b0}}};
    end else if (te <= 0) begin
      result = {rsign, {(W-1){1'b0}}};
      underflow = 1'b1;
      inexact = 1'b1;
    end else if (te >= (1 << EXP_W) - 1 || pk[W-2:FRAC_W] == EXP_ONES)
    begin
      result = {rsign, ovf_inf ? INF_MAG : MAX_MAG};
      overflow = 1'b1;
      inexact = 1'b1;
    end else begin
      result = {rsign, pk};
      inexact = rnd | stk;
    end
    // negation after rounding, never on a NaN
    if (negate & ~is_nan) result[W-1] = ~result[W-1];
  end
endmodule // fp_fused_core

// File: test/fp_unit_chk.sv
// port-level checker for the float execution slice
`timescale 1ns/1ps
`include "fp_unit_map.vh"
module fp_unit_chk (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // issue side
  input wire issue_valid,
  input wire [31:0] instr,
  input wire coprocessor_enabled,
  input wire [1:0] rounding_mode,
  input wire [63:0] tested_integer_value,
  input wire [63:0] base_integer_value,
  input wire [63:0] index_integer_value,
  input wire [63:0] source_float_value,
  input wire [63:0] second_float_value,
  input wire [63:0] addend_float_value,
  input wire page_uncached,
  // results
  input wire result_valid,
  input wire result_write,
  input wire result_write_upper,
  input wire [4:0] result_register,
  input wire [63:0] result_data,
  input wire exc_cop_unusable,
  input wire exc_reserved_instr,
  input wire exc_inexact,
  input wire exc_invalid,
  input wire exc_underflow,
  input wire exc_overflow,
  input wire prefetch_valid,
  input wire [63:0] prefetch_address,
  input wire [4:0] prefetch_hint
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // decode of the offered instruction
  // ----------
  wire go = issue_valid && coprocessor_enabled;
  wire fop = go && instr[31:26] == `OPC_FLOAT_OP;
  wire [4:0] fm = instr[25:21];
  wire movz = fop && (fm == `FMT_SINGLE || fm == `FMT_DOUBLE) &&
              instr[5:0] == `FN_MOVE_ON_ZERO;
  wire negd = fop && fm == `FMT_DOUBLE && instr[20:16] == 5'h00 &&
              instr[5:0] == `FN_NEGATE;
  wire mtc = fop && fm == `FMT_MOVE_TO && instr[10:0] == 11'h000;
  wire pref = go && instr[31:26] == `OPC_EXT_FLOAT_OP &&
              instr[10:0] == {5'h00, `FN_INDEXED_PREFETCH};
  wire flags = exc_inexact || exc_invalid || exc_underflow || exc_overflow;
  // ----------
  // assertions
  // ----------
  AST_ANSWER: assert property (issue_valid |=> result_valid)
    else $error("no answer one cycle after issue");
  AST_IDLE_QUIET: assert property (!issue_valid |=>
    !result_valid && !result_write && !prefetch_valid)
    else $error("strobe without an issue");
  AST_MOVZ_COPY: assert property (movz && tested_integer_value == 0 |=>
    result_write && result_register == $past(instr[10:6]) &&
    result_data[31:0] == $past(source_float_value[31:0]))
    else $error("move on zero did not copy");
  AST_MOVZ_HOLD: assert property (movz && tested_integer_value != 0 |=>
    !result_write && !result_write_upper)
    else $error("failed move wrote destination");
  AST_MOVZ_QUIET: assert property (movz |=> !flags)
    else $error("conditional move raised a flag");
  AST_NEG_SIGN: assert property (negd |=> result_data ==
    {~$past(source_float_value[63]), $past(source_float_value[62:0])})
    else $error("negate changed more than the sign");
  AST_PREF_ADDR: assert property (pref |=> prefetch_address ==
    $past(base_integer_value) + $past(index_integer_value))
    else $error("prefetch address not base plus index");
  AST_PREF_QUIET: assert property (pref |=>
    !result_write && !result_write_upper && !flags)
    else $error("prefetch changed visible state");
  AST_PREF_UNCACHED: assert property (pref && page_uncached |=>
    !prefetch_valid)
    else $error("prefetch toward uncached memory");
  AST_WORD_LOW: assert property (mtc |=> result_write &&
    !result_write_upper &&
    result_data[31:0] == $past(tested_integer_value[31:0]))
    else $error("word move did not copy low word");
  AST_UNUSABLE: assert property (issue_valid && !coprocessor_enabled |=>
    exc_cop_unusable && !result_write && !prefetch_valid)
    else $error("disabled unit did not refuse");
endmodule // fp_unit_chk

bind fp_cond_move_multiply_unit fp_unit_chk u_chk (.*);

// File: test/fp_reg_file_model.sv
// float register file model behind the result write port
`timescale 1ns/1ps
module fp_reg_file_model (
  // clock
  input wire clk,
  // write port
  input wire wr_lo,
  input wire wr_hi,
  input wire [4:0] wr_sel,
  input wire [63:0] wr_data,
  // read port
  input wire [4:0] rd_sel,
  output wire [63:0] rd_data
);
  reg [63:0] mem_q [0:31];
  // halves kept apart: unwritten halves stay unknown, as in hardware
  always @(posedge clk) begin
    if (wr_lo) mem_q[wr_sel][31:0] <= wr_data[31:0];
    if (wr_hi) mem_q[wr_sel][63:32] <= wr_data[63:32];
  end
  assign rd_data = mem_q[rd_sel];
endmodule // fp_reg_file_model

// File: test/fp_cond_move_multiply_unit_tb_top.sv
// self-checking bench for the float execution slice
`timescale 1ns/1ps
`include "fp_unit_map.vh"
module fp_cond_move_multiply_unit_tb_top;
  // ----------
  // signals and encodings
  // ----------
  localparam [4:0] S = `FMT_SINGLE, D = `FMT_DOUBLE, MT = `FMT_MOVE_TO;
  localparam [5:0] MUL = `FN_FLOAT_MULTIPLY, MOVZ = `FN_MOVE_ON_ZERO;
  localparam [5:0] NEG = `FN_NEGATE;
  localparam [2:0] S3 = `FMT3_SINGLE, D3 = `FMT3_DOUBLE;
  logic clk, rst_n, iv, ce, unc, m_ce, m_unc;
  logic [1:0] rm, m_rm;
  logic [31:0] ins;
  logic [63:0] sa, sb, sc, tv, bv, xv;
  logic [4:0] rsel;
  wire rv, rw, ru, ecu, eri, eix, ein, eun, eov, pv;
  wire [4:0] rr, ph;
  wire [63:0] rd, pa, rfd;
  wire [9:0] fl = {rv, rw, ru, ecu, eri, eix, ein, eun, eov, pv};
  int fail_count = 0, total_checks = 0, cyc = 0;

  fp_cond_move_multiply_unit u_fp_cond_move_multiply_unit (.clk(clk),
    .rst_n(rst_n), .issue_valid(iv), .instr(ins),
    .coprocessor_enabled(ce), .rounding_mode(rm),
    .tested_integer_value(tv), .base_integer_value(bv),
    .index_integer_value(xv), .source_float_value(sa),
    .second_float_value(sb), .addend_float_value(sc),
    .page_uncached(unc), .result_valid(rv), .result_write(rw),
    .result_write_upper(ru), .result_register(rr), .result_data(rd),
    .exc_cop_unusable(ecu), .exc_reserved_instr(eri), .exc_inexact(eix),
    .exc_invalid(ein), .exc_underflow(eun), .exc_overflow(eov),
    .prefetch_valid(pv), .prefetch_address(pa), .prefetch_hint(ph));
  fp_reg_file_model u_fp_reg_file_model (.clk(clk), .wr_lo(rw),
    .wr_hi(ru), .wr_sel(rr), .wr_data(rd), .rd_sel(rsel), .rd_data(rfd));

  // core clock, 4 ns
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // hang guard, far above the under one hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      stop_test;
    end
  end
  // ----------
  // helpers
  // ----------
  function automatic [31:0] fop(input [4:0] f, r, s, d, input [5:0] n);
    fop = {`OPC_FLOAT_OP, f, r, s, d, n};
  endfunction
  function automatic [31:0] xop(input [4:0] r, t, s, d, input [2:0] n, m);
    xop = {`OPC_EXT_FLOAT_OP, r, t, s, d, n, m};
  endfunction
  function automatic [31:0] pfx(input [4:0] h);
    pfx = {`OPC_EXT_FLOAT_OP, 5'd1, 5'd2, h, 5'd0, `FN_INDEXED_PREFETCH};
  endfunction
  task automatic chkv(input string n, input [63:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkf(input [9:0] e);
    total_checks++;
    if (fl !== e) begin
      fail_count++;
      $display("[FAIL] strobes of %h exp %b got %b", ins, e, fl);
    end
  endtask
  // one issue, result looked at in its single answer cycle
  task automatic issue(input [31:0] i, input [63:0] a, b, c, t);
    @(posedge clk);
    {iv, ins, sa, sb, sc, tv} <= {1'b1, i, a, b, c, t};
    {rm, ce, unc} <= {m_rm, m_ce, m_unc};
    @(posedge clk);
    iv <= 0;
    #1;
  endtask
  task automatic op(input [31:0] i, input [63:0] a, b, c, t,
                    input [9:0] ef, input [63:0] ed);
    issue(i, a, b, c, t);
    chkf(ef);
    if (ed !== 'x) chkv("data", ed, rd);
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_mul;
    op(fop(D, 2, 4, 6, MUL), 64'h4000000000000000, 64'h4008000000000000,
       0, 0, 10'b1110000000, 64'h4018000000000000);
    op(fop(S, 2, 1, 3, MUL), 64'h3fc00000, 64'h3fc00000, 0, 0,
       10'b1100000000, 64'h40100000);
    op(fop(S, 2, 1, 3, MUL), 64'h3f800001, 64'h3f800001, 0, 0,
       10'b1100010000, 64'h3f800002);
    m_rm = `RM_UP;
    op(fop(S, 2, 1, 3, MUL), 64'h3f800001, 64'h3f800001, 0, 0,
       10'b1100010000, 64'h3f800003);
    m_rm = `RM_DOWN;
    op(fop(S, 2, 1, 3, MUL), 64'hbf800001, 64'h3f800001, 0, 0,
       10'b1100010000, 64'hbf800003);
    m_rm = `RM_ZERO;
    op(fop(S, 2, 1, 3, MUL), 64'hbf800001, 64'h3f800001, 0, 0,
       10'b1100010000, 64'hbf800002);
    m_rm = `RM_NEAREST;
    op(fop(S, 2, 1, 3, MUL), 64'h7f800000, 0, 0, 0,
       10'b1100001000, 64'h7fc00000);
    op(fop(S, 2, 1, 3, MUL), 64'h00800000, 64'h3f000000, 0, 0,
       10'b1100010100, 0);
  endtask
  task automatic t_fused;
    op(xop(4, 2, 1, 3, `FN3_FUSED_SUB, S3), 64'h40000000, 64'h40400000,
       64'h3f800000, 0, 10'b1100000000, 64'h40a00000);
    op(xop(4, 2, 1, 3, `FN3_NEG_ADD, S3), 64'h40000000, 64'h40400000,
       64'h3f800000, 0, 10'b1100000000, 64'hc0e00000);
    op(xop(4, 2, 1, 3, `FN3_NEG_SUB, S3), 64'h40000000, 64'h40400000,
       64'h3f800000, 0, 10'b1100000000, 64'hc0a00000);
    op(xop(4, 2, 1, 3, `FN3_FUSED_SUB, S3), 64'h3f800001, 64'h3f800001,
       64'h3f800002, 0, 10'b1100000000, 64'h28800000);
    op(xop(4, 2, 6, 8, `FN3_NEG_ADD, D3), 64'h4000000000000000,
       64'h4008000000000000, 64'h3ff0000000000000, 0,
       10'b1110000000, 64'hc01c000000000000);
  endtask
  task automatic t_neg;
    op(fop(S, 0, 1, 3, NEG), 64'h3f800000, 0, 0, 0,
       10'b1100000000, 64'hbf800000);
    op(fop(S, 0, 1, 3, NEG), 64'h7f800001, 0, 0, 0,
       10'b1100001000, 64'hff800001);
    op(fop(D, 0, 2, 4, NEG), 64'h4000000000000000, 0, 0, 0,
       10'b1110000000, 64'hc000000000000000);
  endtask
  // word move then failing move to the same register, back to back
  task automatic t_movz;
    @(posedge clk);
    {iv, ins, tv} <= {1'b1, fop(MT, 1, 4, 0, 0), 64'h11112222aaaa5555};
    @(posedge clk);
    {ins, sa, tv} <= {fop(S, 1, 2, 4, MOVZ), 64'h3f800000, 64'h1};
    @(posedge clk);
    iv <= 0;
    #1 chkf(10'b1000000000);
    rsel = 5'd4;
    @(posedge clk);
    #1 chkv("kept", 64'haaaa5555, {32'h0, rfd[31:0]});
    op(fop(S, 0, 2, 5, MOVZ), 64'h40490fdb, 0, 0, 0,
       10'b1100000000, 64'h40490fdb);
    chkv("dest", 5, rr);
    op(fop(D, 0, 2, 6, MOVZ), 64'h7ff0000000000001, 0, 0, 0,
       10'b1110000000, 64'h7ff0000000000001);
  endtask
  task automatic t_mtc;
    op(fop(MT, 1, 7, 0, 0), 0, 0, 0, 64'hdeadbeef12345678,
       10'b1100000000, 64'h12345678);
    chkv("dest", 7, rr);
  endtask
  task automatic t_pref;
    @(posedge clk);
    {bv, xv} <= {64'hfffffff0, 64'h20};
    op(pfx(5), 0, 0, 0, 0, 10'b1000000001, 'x);
    chkv("addr", 64'h100000010, pa);
    chkv("hint", 5, ph);
    op(pfx(3), 0, 0, 0, 0, 10'b1000000001, 'x);
    chkv("hint", 0, ph);
    m_unc = 1;
    op(pfx(0), 0, 0, 0, 0, 10'b1000000000, 'x);
    m_unc = 0;
  endtask
  task automatic t_refuse;
    m_ce = 0;
    op(fop(D, 2, 4, 6, MUL), 64'h4000000000000000, 0, 0, 0,
       10'b1001000000, 'x);
    m_ce = 1;
    op(xop(4, 2, 1, 3, 3'h4, S3), 0, 0, 0, 0, 10'b1000100000, 'x);
  endtask
  // ----------
  // main sequence and verdict
  // ----------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, iv, ce, unc, rm, ins, rsel} = {4'b0010, 2'b00, 32'h0, 5'h0};
    {sa, sb, sc, tv, bv, xv} = '0;
    {m_ce, m_unc, m_rm} = {1'b1, 1'b0, `RM_NEAREST};
    repeat (10) @(posedge clk);
    rst_n <= 1;
    t_mul;
    t_fused;
    t_neg;
    t_movz;
    t_mtc;
    t_pref;
    t_refuse;
    stop_test;
  end
endmodule // fp_cond_move_multiply_unit_tb_top
